// *** rtl/motor_combo_pkg.sv ***
package motor_combo_pkg;

    // ------------------------------------------------------------
    // register addresses on the serial port
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_SYS_CTRL = 8'h9E;
    localparam logic [7:0] ADDR_TEST_CTRL = 8'hAE;
    localparam logic [7:0] ADDR_COIL_CTRL = 8'hBE;
    localparam logic [7:0] ADDR_REVISION = 8'hFF;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ------------------------------------------------------------
    // serial frame layout: address byte then data byte, msb first
    // ------------------------------------------------------------
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] ADDR_LAST_BIT = 5'h07;
    localparam logic [4:0] FRAME_LAST_BIT = 5'h0F;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SYS_PARK_A = 0;
    localparam int SYS_PARK_B = 1;
    localparam int SYS_RT_LO = 3;
    localparam int SYS_RT_HI = 6;
    localparam int SYS_RETRACT = 7;
    localparam int TST_SPEED_SEL = 4;
    localparam int TST_REVERSE_BRAKE_CMD = 5;
    localparam int TST_BOOST_DIS = 7;
    localparam int COIL_CHOP_SLEW = 0;
    localparam int COIL_FORCE_HIGH = 1;
    localparam int COIL_COMM_SLEW = 3;
    localparam int COIL_TRISTATE = 5;
    localparam int COIL_BRAKE = 6;

    // ------------------------------------------------------------
    // decoded values: millivolts and milliseconds
    // ------------------------------------------------------------
    localparam logic [10:0] PARK_MV_00 = 11'h352; // 850
    localparam logic [10:0] PARK_MV_01 = 11'h28A; // 650
    localparam logic [10:0] PARK_MV_10 = 11'h640; // 1600
    localparam logic [10:0] PARK_MV_11 = 11'h47E; // 1150
    localparam logic [8:0] RETRACT_MS_00 = 9'h0A0; // 160
    localparam logic [8:0] RETRACT_MS_01 = 9'h140; // 320
    localparam logic [8:0] RETRACT_MS_10 = 9'h050; // 80
    localparam logic [8:0] RETRACT_MS_11 = 9'h0A0; // 160

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLOCK_PERIOD_NS;

    typedef enum logic [1:0] {
        RET_IDLE = 2'b00,
        RET_HALF1 = 2'b01,
        RET_HALF2 = 2'b10
    } retract_state_t;

endpackage

// *** rtl/serial_frame_rx.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_frame_rx
    import motor_combo_pkg::*;
(
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic en_i,
    input wire logic cs_i,
    input wire logic sclk_i,
    input wire logic sdi_i,
    input wire logic [7:0] rev_i,
    output logic wr_stb_o,
    output logic [7:0] addr_o,
    output logic [7:0] data_o,
    output logic sdo_o,
    output logic sdo_oe_o
);

    typedef struct packed {
        logic sclk_prev;
        logic [4:0] cnt;
        logic [7:0] sh;
        logic [7:0] addr;
        logic [7:0] data;
        logic wr;
        logic [7:0] out_sh;
        logic oe;
    } rx_state_t;

    rx_state_t q, d;
    logic rise;
    logic [7:0] next_sh;

    // ------------------------------------------------------------
    // frame shifter: bits taken on the rising edge of the port clock
    // ------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.wr = 1'b0;
        d.sclk_prev = sclk_i;
        rise = sclk_i && !q.sclk_prev;
        next_sh = {q.sh[6:0], sdi_i};
        if (!cs_i)
        begin
            // deselect abandons a short frame, nothing is committed
            d.cnt = 5'h00;
            d.oe = 1'b0;
            d.out_sh = 8'h00;
        end
        else if (rise && q.cnt < FRAME_BITS)
        begin
            d.sh = next_sh;
            d.cnt = q.cnt + 5'h01;
            if (q.cnt == ADDR_LAST_BIT)
            begin
                d.addr = next_sh;
                if (next_sh == ADDR_REVISION) // only the revision place drives back
                begin
                    d.out_sh = rev_i;
                    d.oe = 1'b1;
                end
            end
            else if (q.cnt > ADDR_LAST_BIT)
            begin
                d.out_sh = {q.out_sh[6:0], 1'b0};
            end
            if (q.cnt == FRAME_LAST_BIT)
            begin
                d.data = next_sh;
                d.wr = (q.addr != ADDR_REVISION);
                d.oe = 1'b0;
                d.out_sh = 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
            q <= '0;
        else if (en_i)
            q <= d;
    end

    assign wr_stb_o = q.wr;
    assign addr_o = q.addr;
    assign data_o = q.data;
    // shifter is cleared whenever oe drops, so no gating is needed here
    assign sdo_o = q.out_sh[7];
    assign sdo_oe_o = q.oe;

endmodule
`default_nettype wire

// *** rtl/motor_combo_ctrl_regs.sv ***
// What this block does
// - park select bits give four parking voltages
// - retract bits give 160/320/80/160 ms duration
// - output select routes speed loop or zero-cross
// - reverse brake blocks start until cleared
// - bit 7 disables boost; unused bits zero
// - chop slew: 10 or 20 V/us
// - force coil outputs high in chopping mode
// - commutation slew: 30 or 2 V/us
// - tristate coil for half retract time
// - brake coil for half retract time
// - power-save bit ignored; bits 4,7 zero
// - read-only revision register at FFh
// - test and coil registers give no readback
// - system register field positions as listed
`timescale 1ns/1ps
`default_nettype none
module motor_combo_ctrl_regs
    import motor_combo_pkg::*;
#(
    parameter int MS_CYCLES_P = MS_CYCLES,
    parameter logic [7:0] REVISION_P = 8'h5A // arbitrary value
)
(
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic en_i,
    input wire logic cs_i,
    input wire logic sclk_i,
    input wire logic sdi_i,
    input wire logic speed_loop_i,
    input wire logic zero_cross_i,
    input wire logic phase_shift_chopping_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    output logic [10:0] park_volt_mv_o,
    output logic [8:0] retract_time_ms_o,
    output logic retract_active_o,
    output logic coil_tristate_o,
    output logic coil_brake_o,
    output logic coil_chop_slew_sel_o,
    output logic coil_force_high_o,
    output logic commutation_slew_sel_o,
    output logic boost_disable_o,
    output logic reverse_brake_o,
    output logic spindle_start_allow_o,
    output logic spindle_feedback_pin_o
);

    // ------------------------------------------------------------
    // decode functions
    // ------------------------------------------------------------
    function automatic logic [10:0] park_mv_f(input logic sel_a, input logic sel_b);
        case ({sel_a, sel_b})
            2'b00: park_mv_f = PARK_MV_00;
            2'b01: park_mv_f = PARK_MV_01;
            2'b10: park_mv_f = PARK_MV_10;
            default: park_mv_f = PARK_MV_11;
        endcase
    endfunction

    function automatic logic [8:0] retract_ms_f(input logic lo, input logic hi);
        case ({lo, hi})
            2'b00: retract_ms_f = RETRACT_MS_00;
            2'b01: retract_ms_f = RETRACT_MS_01;
            2'b10: retract_ms_f = RETRACT_MS_10;
            default: retract_ms_f = RETRACT_MS_11;
        endcase
    endfunction

    typedef struct packed {
        logic [7:0] sys_ctrl;
        logic [7:0] test_ctrl;
        logic [7:0] coil_ctrl;
        logic [10:0] park_mv;
        logic [8:0] retract_ms;
        logic [7:0] half_ms;
        retract_state_t ret_state;
        logic [16:0] pre;
        logic [7:0] ms_cnt;
        logic tristate;
        logic brake;
        logic force_high;
        logic feedback;
        logic active;
        logic start_allow;
    } ctrl_state_t;

    ctrl_state_t q, d;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic ms_tick;

    // ------------------------------------------------------------
    // serial port
    // ------------------------------------------------------------
    serial_frame_rx u_rx (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .en_i(en_i),
        .cs_i(cs_i),
        .sclk_i(sclk_i),
        .sdi_i(sdi_i),
        .rev_i(REVISION_P),
        .wr_stb_o(wr_stb),
        .addr_o(wr_addr),
        .data_o(wr_data),
        .sdo_o(sdo_o),
        .sdo_oe_o(sdo_oe_o)
    );

    // ------------------------------------------------------------
    // register file, decodes and retract sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        d = q;
        ms_tick = (q.pre == 17'(MS_CYCLES_P - 1));
        // registers change only on a completed frame
        if (wr_stb)
        begin
            case (wr_addr)
                ADDR_SYS_CTRL: d.sys_ctrl = wr_data;
                ADDR_TEST_CTRL: d.test_ctrl = wr_data;
                ADDR_COIL_CTRL: d.coil_ctrl = wr_data;
                default: d.sys_ctrl = q.sys_ctrl; // revision and unmapped ignored
            endcase
        end
        d.park_mv = park_mv_f(d.sys_ctrl[SYS_PARK_A], d.sys_ctrl[SYS_PARK_B]);
        d.retract_ms = retract_ms_f(d.sys_ctrl[SYS_RT_LO], d.sys_ctrl[SYS_RT_HI]);
        d.feedback = q.test_ctrl[TST_SPEED_SEL] ? speed_loop_i : zero_cross_i;
        d.force_high = q.coil_ctrl[COIL_FORCE_HIGH] & phase_shift_chopping_i;

        // millisecond prescaler only runs during a retract to save toggling
        if (q.ret_state == RET_IDLE || ms_tick)
            d.pre = 17'h00000;
        else
            d.pre = q.pre + 17'h00001;

        case (q.ret_state)
            RET_IDLE:
            begin
                d.ms_cnt = 8'h00;
                if (wr_stb && wr_addr == ADDR_SYS_CTRL && wr_data[SYS_RETRACT])
                begin
                    // duration latched at start so a rewrite mid-retract cannot stretch it
                    d.half_ms = d.retract_ms[8:1];
                    d.ret_state = RET_HALF1;
                end
            end
            RET_HALF1:
            begin
                if (ms_tick)
                begin
                    d.ms_cnt = q.ms_cnt + 8'h01;
                    if (d.ms_cnt == q.half_ms)
                    begin
                        d.ms_cnt = 8'h00;
                        d.ret_state = RET_HALF2;
                    end
                end
            end
            RET_HALF2:
            begin
                if (ms_tick)
                begin
                    d.ms_cnt = q.ms_cnt + 8'h01;
                    if (d.ms_cnt == q.half_ms)
                    begin
                        d.ms_cnt = 8'h00;
                        d.ret_state = RET_IDLE;
                    end
                end
            end
            default: d.ret_state = RET_IDLE;
        endcase
        // tristate wins over brake if both are set
        d.tristate = (d.ret_state == RET_HALF1) && q.coil_ctrl[COIL_TRISTATE];
        d.brake = (d.ret_state == RET_HALF1) && !q.coil_ctrl[COIL_TRISTATE]
            && q.coil_ctrl[COIL_BRAKE];
        // flopped copies so the outputs carry no gate after the register
        d.active = (d.ret_state != RET_IDLE);
        d.start_allow = !d.test_ctrl[TST_REVERSE_BRAKE_CMD];
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            q <= '0;
            q.park_mv <= PARK_MV_00;
            q.retract_ms <= RETRACT_MS_00;
            q.start_allow <= 1'b1;
        end
        else if (en_i)
            q <= d;
    end

    // ------------------------------------------------------------
    // outputs, all straight from state flops
    // ------------------------------------------------------------
    assign park_volt_mv_o = q.park_mv;
    assign retract_time_ms_o = q.retract_ms;
    assign retract_active_o = q.active;
    assign coil_tristate_o = q.tristate;
    assign coil_brake_o = q.brake;
    assign coil_chop_slew_sel_o = q.coil_ctrl[COIL_CHOP_SLEW];
    assign coil_force_high_o = q.force_high;
    assign commutation_slew_sel_o = q.coil_ctrl[COIL_COMM_SLEW]; // bit 2 unused
    assign boost_disable_o = q.test_ctrl[TST_BOOST_DIS];
    assign reverse_brake_o = q.test_ctrl[TST_REVERSE_BRAKE_CMD];
    assign spindle_start_allow_o = q.start_allow;
    assign spindle_feedback_pin_o = q.feedback;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    property p_park_decode;
        en_i && wr_stb && wr_addr == ADDR_SYS_CTRL
        |=> park_volt_mv_o == park_mv_f($past(wr_data[0]), $past(wr_data[1]));
    endproperty
    a_park_decode: assert property (p_park_decode) else $error("parking voltage decode wrong");

    property p_retract_decode;
        en_i && wr_stb && wr_addr == ADDR_SYS_CTRL
        |=> retract_time_ms_o == retract_ms_f($past(wr_data[3]), $past(wr_data[6]));
    endproperty
    a_retract_decode: assert property (p_retract_decode) else $error("retract time decode wrong");

    property p_feedback_route;
        en_i |=> spindle_feedback_pin_o == ($past(q.test_ctrl[4]) ? $past(speed_loop_i) : $past(zero_cross_i));
    endproperty
    a_feedback_route: assert property (p_feedback_route) else $error("feedback pin routing wrong");

    property p_brake_holds;
        !spindle_start_allow_o && !(wr_stb && wr_addr == ADDR_TEST_CTRL && !wr_data[5])
        |=> !spindle_start_allow_o;
    endproperty
    a_brake_holds: assert property (p_brake_holds) else $error("start allowed while braking");

    property p_boost;
        en_i && wr_stb && wr_addr == ADDR_TEST_CTRL |=> boost_disable_o == $past(wr_data[7]);
    endproperty
    a_boost: assert property (p_boost) else $error("boost disable not taken");

    property p_force_high;
        en_i |=> coil_force_high_o == ($past(q.coil_ctrl[1]) && $past(phase_shift_chopping_i));
    endproperty
    a_force_high: assert property (p_force_high) else $error("force high wrong");

    property p_tristate_half;
        coil_tristate_o |-> retract_active_o && q.ret_state == RET_HALF1 && !coil_brake_o;
    endproperty
    a_tristate_half: assert property (p_tristate_half) else $error("tristate outside first half");

    property p_no_readback;
        sdo_oe_o |-> wr_addr == ADDR_REVISION;
    endproperty
    a_no_readback: assert property (p_no_readback) else $error("readback on write-only register");

    property p_frame_commit;
        $changed(q.coil_ctrl) |-> $past(wr_stb) && $past(wr_addr) == ADDR_COIL_CTRL;
    endproperty
    a_frame_commit: assert property (p_frame_commit) else $error("register changed without frame");

    c_retract: cover property (retract_active_o ##1 coil_tristate_o);
    c_brake: cover property (coil_brake_o);
    c_read_rev: cover property (sdo_oe_o);
    c_reverse_brake_cmd: cover property (!spindle_start_allow_o ##[1:300] spindle_start_allow_o);

endmodule
`default_nettype wire

// *** bench/host_serial_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_serial_model
(
    input wire logic clock_i,
    input wire logic sdo_i,
    input wire logic sdo_oe_i,
    output logic cs_o,
    output logic sclk_o,
    output logic sdi_o
);
    // ------------------------------------------------------------
    // serial master: sclk stands low outside frames
    // ------------------------------------------------------------
    initial
    begin
        cs_o = 1'b0;
        sclk_o = 1'b0;
        sdi_o = 1'b0;
    end

    // address then data msb first; nbits may cut a frame or overrun it
    task automatic frame(input logic [7:0] addr, input logic [7:0] data, input int nbits, input int hp,
                         output logic [7:0] rdata, output logic oe_seen);
        logic [15:0] word;
        word = {addr, data};
        rdata = 8'h00;
        oe_seen = 1'b0;
        @(posedge clock_i);
        #1 cs_o = 1'b1;
        for (int k = 0; k < nbits; k++)
        begin
            sclk_o = 1'b0;
            sdi_o = word[15 - (k % 16)];
            repeat (hp) @(posedge clock_i);
            #1 sclk_o = 1'b1;
            repeat (hp) @(posedge clock_i);
            #1;
            // hp of two or more lets the registered sdo settle first
            if (k >= 7 && k < 15)
            begin
                rdata[14 - k] = sdo_i;
                oe_seen = oe_seen | (sdo_oe_i === 1'b1);
            end
        end
        sclk_o = 1'b0;
        sdi_o = ~sdi_o; // released line shows no stale value
        @(posedge clock_i);
        #1 cs_o = 1'b0;
        repeat (3) @(posedge clock_i);
        #1;
    endtask
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import motor_combo_pkg::*;
    localparam int MSC = 10;
    localparam logic [7:0] REV = 8'hC3; // arbitrary value
    logic clock_i, nrst_i, en_i, speed_loop_i, zero_cross_i, phase_shift_chopping_i;
    logic cs, sclk, sdi, sdo, sdo_oe, ret_act, coil_tri, coil_brk, chop_slew, force_high;
    logic comm_slew, boost_dis, reverse_brake_cmd, start_allow, fb_pin, oe;
    logic [10:0] park_mv;
    logic [8:0] rt_ms;
    logic [7:0] rdv, d;
    logic [31:0] r;
    int seed = 32'h8FC606A6;
    int mismatches = 0, cmp_count = 0, cyc = 0, tri_n = 0, brk_n = 0, act_n = 0;

    motor_combo_ctrl_regs #(.MS_CYCLES_P(MSC), .REVISION_P(REV)) dut (.clock_i(clock_i), .nrst_i(nrst_i),
        .en_i(en_i), .cs_i(cs), .sclk_i(sclk), .sdi_i(sdi), .speed_loop_i(speed_loop_i),
        .zero_cross_i(zero_cross_i), .phase_shift_chopping_i(phase_shift_chopping_i), .sdo_o(sdo),
        .sdo_oe_o(sdo_oe), .park_volt_mv_o(park_mv), .retract_time_ms_o(rt_ms), .retract_active_o(ret_act),
        .coil_tristate_o(coil_tri), .coil_brake_o(coil_brk), .coil_chop_slew_sel_o(chop_slew),
        .coil_force_high_o(force_high), .commutation_slew_sel_o(comm_slew), .boost_disable_o(boost_dis),
        .reverse_brake_o(reverse_brake_cmd), .spindle_start_allow_o(start_allow), .spindle_feedback_pin_o(fb_pin));
    host_serial_model host (.clock_i(clock_i), .sdo_i(sdo), .sdo_oe_i(sdo_oe), .cs_o(cs), .sclk_o(sclk),
        .sdi_o(sdi));

    // ------------------------------------------------------------
    // expectations and helpers
    // ------------------------------------------------------------
    function automatic logic [10:0] park_exp(input logic a, input logic b);
        case ({a, b})
            2'b00: return PARK_MV_00;
            2'b01: return PARK_MV_01;
            2'b10: return PARK_MV_10;
            default: return PARK_MV_11;
        endcase
    endfunction

    function automatic logic [8:0] rt_exp(input logic lo, input logic hi);
        case ({lo, hi})
            2'b00: return RETRACT_MS_00;
            2'b01: return RETRACT_MS_01;
            2'b10: return RETRACT_MS_10;
            default: return RETRACT_MS_11;
        endcase
    endfunction

    // the half-way split may land one cycle either side
    function automatic logic near(input int n, input int e, input int tol);
        return (n >= e - tol) && (n <= e + tol);
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic xfer(input logic [7:0] a, input logic [7:0] dv, input int n);
        r = $random(seed);
        host.frame(a, dv, n, 2 + r[0], rdv, oe);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] dv);
        xfer(a, dv, 16);
    endtask

    task automatic wait_idle();
        for (int k = 0; k < 5000 && ret_act !== 1'b0; k++)
            @(posedge clock_i);
        #1;
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock, pulse-length monitor and hang guard
    // ------------------------------------------------------------
    initial
    begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    always @(posedge clock_i)
    begin
        cyc <= cyc + 1;
        if (coil_tri === 1'b1) tri_n <= tri_n + 1;
        if (coil_brk === 1'b1) brk_n <= brk_n + 1;
        if (ret_act === 1'b1) act_n <= act_n + 1;
        if (cyc == 40000)
        begin
            mismatches++;
            results();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        nrst_i = 1'b0;
        en_i = 1'b1;
        speed_loop_i = 1'b0;
        zero_cross_i = 1'b0;
        phase_shift_chopping_i = 1'b0;
        repeat (12) @(posedge clock_i);
        #1 nrst_i = 1'b1;
        @(posedge clock_i);
        #1;
        check("park_reset", park_mv, PARK_MV_00);
        check("retract_reset", rt_ms, RETRACT_MS_00);
        check("start_allow_reset", start_allow, 1);
        check("outs_reset", {ret_act, coil_tri, coil_brk, chop_slew, comm_slew, boost_dis, reverse_brake_cmd, sdo_oe}, 0);
        // every park and retract code, loose bits random
        for (int i = 0; i < 16; i++)
        begin
            r = $random(seed);
            wr(8'h8E, r[7:0] & 8'hFB);
            d = {1'b0, i[3], r[5:4], i[2], r[2], i[1], i[0]};
            wr(ADDR_SYS_CTRL, d);
            check("park", park_mv, park_exp(i[0], i[1]));
            check("retract_ms", rt_ms, rt_exp(i[2], i[3]));
            check("no_retract", ret_act, 0);
        end
        // test control: unused bits kept zero
        for (int i = 0; i < 8; i++)
        begin
            wr(ADDR_TEST_CTRL, {i[2], 1'b0, i[1], i[0], 4'h0});
            check("reverse_brake_cmd", reverse_brake_cmd, i[1]);
            check("start_allow", start_allow, !i[1]);
            check("boost_dis", boost_dis, i[2]);
            r = $random(seed);
            speed_loop_i = r[8];
            zero_cross_i = ~r[8];
            @(posedge clock_i);
            #1;
            check("feedback", fb_pin, i[0] ? r[8] : !r[8]);
        end
        wr(ADDR_TEST_CTRL, 8'h00);
        check("start_allow_back", start_allow, 1);
        // coil control: bit 2 random, bits 4 and 7 zero
        for (int i = 0; i < 8; i++)
        begin
            r = $random(seed);
            wr(ADDR_COIL_CTRL, {4'h0, i[2], r[0], i[1], i[0]});
            check("chop_slew", chop_slew, i[0]);
            check("comm_slew", comm_slew, i[2]);
            phase_shift_chopping_i = r[1];
            @(posedge clock_i);
            #1;
            check("force_high", force_high, i[1] & r[1]);
        end
        // revision reads, write ignored, write-only places silent
        xfer(ADDR_REVISION, 8'h00, 16);
        check("rev", rdv, REV);
        check("rev_oe", oe, 1);
        wr(ADDR_REVISION, ~REV);
        xfer(ADDR_REVISION, 8'h00, 16);
        check("rev_after_wr", rdv, REV);
        // these frames also write: the system place gets park code 11 for the cut-frame checks
        for (int j = 0; j < 3; j++)
        begin
            xfer(j == 0 ? ADDR_TEST_CTRL : j == 1 ? ADDR_COIL_CTRL : ADDR_SYS_CTRL, j == 2 ? 8'h03 : 8'h00, 16);
            check("wo_oe", oe, 0);
        end
        // cut frame, frozen frame, overrun frame
        xfer(ADDR_SYS_CTRL, 8'h01, 12);
        check("park_cut", park_mv, park_exp(1, 1));
        en_i = 1'b0;
        wr(ADDR_SYS_CTRL, 8'h01);
        en_i = 1'b1;
        check("park_frozen", park_mv, park_exp(1, 1));
        xfer(ADDR_SYS_CTRL, 8'h02, 18);
        check("park_overrun", park_mv, park_exp(0, 1));
        // tristate half of a 160 ms retract, second request ignored
        wr(ADDR_COIL_CTRL, 8'h20);
        tri_n = 0;
        brk_n = 0;
        act_n = 0;
        wr(ADDR_SYS_CTRL, 8'h82);
        wr(ADDR_SYS_CTRL, 8'hC2);
        wait_idle();
        check("tri_len", near(tri_n, 80 * MSC, 1), 1);
        check("act_len", near(act_n, 160 * MSC, 2), 1);
        check("brk_none", brk_n, 0);
        // brake half of an 80 ms retract
        wr(ADDR_COIL_CTRL, 8'h40);
        tri_n = 0;
        brk_n = 0;
        act_n = 0;
        wr(ADDR_SYS_CTRL, 8'h88);
        wait_idle();
        check("brk_len", near(brk_n, 40 * MSC, 1), 1);
        check("act_len80", near(act_n, 80 * MSC, 2), 1);
        check("tri_none", tri_n, 0);
        results();
    end
endmodule
`default_nettype wire
